// *** core/tft_fault_limits.sv ***
// Purpose: Fault thresholds, alarm suppression and cold-junction offset
// Assumes: Host bytes arrive on a parallel strobe port; write index has bit 7 set
// Notes: Conversion results and fault flags come from the conversion engine
//
// Operation
// - Status bit sets even when its alarm is suppressed
// - Range faults never drive the alarm
// - Suppress register resets FFh; bits 7:6 reserved
// - Suppress bits 5..0 map CJ/TC limits, voltage, open
// - Unsuppressed open or voltage fault drives alarm
// - Cold junction above high limit sets fault
// - Cold junction below low limit sets fault
// - Cold-junction limits are signed whole degrees
// - Thermocouple above two-byte high limit sets fault
// - Thermocouple below two-byte low limit sets fault
// - Thermocouple limits signed, 2^10 down to 2^-4
// - Thermocouple limit reset values 7FFFh and 8000h
// - Signed offset added while internal sensor enabled
// - Comparator mode: status follows live condition
// - Comparator mode: 2 degree release hysteresis
// - Interrupt mode latches until clear strobe

`timescale 1ns/1ns
`default_nettype none

module tft_fault_limits
  import tft_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire tft_req_type REG_REQ,
  input wire logic [CJ_W-1:0] CJ_MEASURED,
  input wire logic CJ_SENSOR_EN,
  input wire logic [TEMP_W-1:0] TC_LINEARIZED,
  input wire tft_flags_type FAULT_FLAGS,
  input wire logic INTERRUPT_MODE,
  input wire logic STATUS_CLEAR_STROBE,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  output logic FAULT_N,
  output logic [7:0] FAULT_STATUS,
  output logic [CJ_W-1:0] CJ_COMPENSATED
);

  // ****************************************
  // State
  // ****************************************
  tft_state_type s_r;
  tft_state_type s_nxt;

  logic cj_hi_active;
  logic cj_lo_active;
  logic tc_hi_active;
  logic tc_lo_active;
  logic hyst_en;

  logic [TEMP_W-1:0] cj_scaled;
  logic [TEMP_W-1:0] cj_hi_scaled;
  logic [TEMP_W-1:0] cj_lo_scaled;
  logic [TEMP_W-1:0] th_scaled;
  logic [TEMP_W-1:0] tl_scaled;

  // ****************************************
  // Scaling onto the common scale
  // ****************************************
  always_comb begin
    // Limits gain fraction bits so every compare uses one scale
    cj_scaled = {{4{s_r.cj_comp[CJ_W-1]}}, s_r.cj_comp, 1'b0};
    cj_hi_scaled = {{4{s_r.regs.cj_hi[7]}}, s_r.regs.cj_hi, 7'h00};
    cj_lo_scaled = {{4{s_r.regs.cj_lo[7]}}, s_r.regs.cj_lo, 7'h00};
    th_scaled = {s_r.regs.th_upper, s_r.regs.th_lower, 3'h0};
    tl_scaled = {s_r.regs.tl_upper, s_r.regs.tl_lower, 3'h0};
    // Latched mode holds bits itself; a release band would only delay a clear
    hyst_en = ~INTERRUPT_MODE;
  end

  // ****************************************
  // Limit comparators
  // ****************************************
  // Each comparator adds one flop between its inputs and its flag
  tft_limit_cmp #(
    .HIGH_SIDE(1'b1)
  ) u_cj_hi (
    .clock(CLOCK),
    .rst(RST),
    .value(cj_scaled),
    .limit(cj_hi_scaled),
    .hyst_en(hyst_en),
    .active(cj_hi_active)
  );

  tft_limit_cmp #(
    .HIGH_SIDE(1'b0)
  ) u_cj_lo (
    .clock(CLOCK),
    .rst(RST),
    .value(cj_scaled),
    .limit(cj_lo_scaled),
    .hyst_en(hyst_en),
    .active(cj_lo_active)
  );

  tft_limit_cmp #(
    .HIGH_SIDE(1'b1)
  ) u_tc_hi (
    .clock(CLOCK),
    .rst(RST),
    .value(TC_LINEARIZED),
    .limit(th_scaled),
    .hyst_en(hyst_en),
    .active(tc_hi_active)
  );

  tft_limit_cmp #(
    .HIGH_SIDE(1'b0)
  ) u_tc_lo (
    .clock(CLOCK),
    .rst(RST),
    .value(TC_LINEARIZED),
    .limit(tl_scaled),
    .hyst_en(hyst_en),
    .active(tc_lo_active)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic [7:0] live;
  logic signed [CJ_W:0] cj_ext;
  logic signed [CJ_W:0] ofs_ext;
  logic signed [CJ_W:0] cj_sum;
  logic [6:0] idx;
  logic wr_en;
  logic rd_en;
  logic cj_ovf;
  logic [7:0] alarm_src;

  always_comb begin
    s_nxt = s_r;
    idx = REG_REQ.addr[6:0];
    wr_en = REG_REQ.stb & REG_REQ.addr[WRITE_FLAG_BIT];
    rd_en = REG_REQ.stb & ~REG_REQ.addr[WRITE_FLAG_BIT];

    // ****************************************
    // Cold-junction offset, saturated to the 14-bit result
    // ****************************************
    cj_ext = $signed({CJ_MEASURED[CJ_W-1], CJ_MEASURED});
    ofs_ext = $signed({{5{s_r.regs.cj_offset[7]}}, s_r.regs.cj_offset, 2'b00});
    if (CJ_SENSOR_EN) begin
      cj_sum = cj_ext + ofs_ext;
    end else begin
      cj_sum = cj_ext;
    end
    // A wrapped sum would flip the sign seen by the comparators
    cj_ovf = cj_sum[CJ_W] != cj_sum[CJ_W-1];
    if (cj_ovf) begin
      s_nxt.cj_comp = {cj_sum[CJ_W], {(CJ_W-1){~cj_sum[CJ_W]}}};
    end else begin
      s_nxt.cj_comp = cj_sum[CJ_W-1:0];
    end

    // ****************************************
    // Live fault conditions in status bit order
    // ****************************************
    live = 8'h00;
    live[BIT_CJ_RANGE] = FAULT_FLAGS.cj_range;
    live[BIT_TC_RANGE] = FAULT_FLAGS.tc_range;
    live[BIT_CJ_HIGH] = cj_hi_active;
    live[BIT_CJ_LOW] = cj_lo_active;
    live[BIT_TC_HIGH] = tc_hi_active;
    live[BIT_TC_LOW] = tc_lo_active;
    live[BIT_VOLT] = FAULT_FLAGS.volt_err;
    live[BIT_OPEN] = FAULT_FLAGS.open_tc;

    // ****************************************
    // Status is set regardless of suppression
    // ****************************************
    if (INTERRUPT_MODE) begin
      // New faults win over a clear in the same cycle
      s_nxt.status = (s_r.status & ~{8{STATUS_CLEAR_STROBE}}) | live;
    end else begin
      // Clear strobe has no effect while the bits follow live levels
      s_nxt.status = live;
    end

    // ****************************************
    // Alarm from suppress-gated status; range bits excluded
    // ****************************************
    alarm_src = s_nxt.status & ALARM_SOURCES & ~s_r.regs.suppress;
    s_nxt.fault_n = ~|alarm_src;

    // ****************************************
    // Register writes
    // ****************************************
    // Status index is read only; its writes fall to the default branch
    if (wr_en) begin
      case (idx)
        IDX_SUPPRESS: begin
          s_nxt.regs.suppress = REG_REQ.wdata | SUPPRESS_RSVD;
        end
        IDX_CJ_HI: begin
          s_nxt.regs.cj_hi = REG_REQ.wdata;
        end
        IDX_CJ_LO: begin
          s_nxt.regs.cj_lo = REG_REQ.wdata;
        end
        IDX_TH_UPPER: begin
          s_nxt.regs.th_upper = REG_REQ.wdata;
        end
        IDX_TH_LOWER: begin
          s_nxt.regs.th_lower = REG_REQ.wdata;
        end
        IDX_TL_UPPER: begin
          s_nxt.regs.tl_upper = REG_REQ.wdata;
        end
        IDX_TL_LOWER: begin
          s_nxt.regs.tl_lower = REG_REQ.wdata;
        end
        IDX_CJ_OFFSET: begin
          s_nxt.regs.cj_offset = REG_REQ.wdata;
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // Register reads; unmapped indexes return zero
    // ****************************************
    s_nxt.rvalid = rd_en;
    if (rd_en) begin
      case (idx)
        IDX_SUPPRESS: begin
          s_nxt.rdata = s_r.regs.suppress;
        end
        IDX_CJ_HI: begin
          s_nxt.rdata = s_r.regs.cj_hi;
        end
        IDX_CJ_LO: begin
          s_nxt.rdata = s_r.regs.cj_lo;
        end
        IDX_TH_UPPER: begin
          s_nxt.rdata = s_r.regs.th_upper;
        end
        IDX_TH_LOWER: begin
          s_nxt.rdata = s_r.regs.th_lower;
        end
        IDX_TL_UPPER: begin
          s_nxt.rdata = s_r.regs.tl_upper;
        end
        IDX_TL_LOWER: begin
          s_nxt.rdata = s_r.regs.tl_lower;
        end
        IDX_CJ_OFFSET: begin
          s_nxt.rdata = s_r.regs.cj_offset;
        end
        IDX_STATUS: begin
          s_nxt.rdata = s_r.status;
        end
        default: begin
          s_nxt.rdata = RST_RDATA;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      // Every alarm source starts out suppressed
      s_r.regs.suppress <= RST_SUPPRESS;
      s_r.regs.cj_hi <= RST_CJ_HI;
      s_r.regs.cj_lo <= RST_CJ_LO;
      s_r.regs.th_upper <= RST_TH_UPPER;
      s_r.regs.th_lower <= RST_TH_LOWER;
      s_r.regs.tl_upper <= RST_TL_UPPER;
      s_r.regs.tl_lower <= RST_TL_LOWER;
      s_r.regs.cj_offset <= RST_CJ_OFFSET;
      s_r.status <= RST_STATUS;
      s_r.fault_n <= 1'b1;
      s_r.cj_comp <= '0;
      s_r.rdata <= RST_RDATA;
      s_r.rvalid <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Each output is a field of the registered state
  assign REG_RDATA = s_r.rdata;
  assign REG_RVALID = s_r.rvalid;
  assign FAULT_N = s_r.fault_n;
  assign FAULT_STATUS = s_r.status;
  assign CJ_COMPENSATED = s_r.cj_comp;

endmodule

`default_nettype wire

// *** core/tft_pkg.sv ***
// Purpose: Shared constants and carrier types for the fault threshold block
// Assumes: Byte-wide register port, index in address bits 6:0
// Notes: Temperatures compare on a common signed 19-bit scale, 7 fraction bits

package tft_pkg;

  // ****************************************
  // Register indexes
  // ****************************************
  localparam logic [6:0] IDX_SUPPRESS = 7'h02;
  localparam logic [6:0] IDX_CJ_HI = 7'h03;
  localparam logic [6:0] IDX_CJ_LO = 7'h04;
  localparam logic [6:0] IDX_TH_UPPER = 7'h05;
  localparam logic [6:0] IDX_TH_LOWER = 7'h06;
  localparam logic [6:0] IDX_TL_UPPER = 7'h07;
  localparam logic [6:0] IDX_TL_LOWER = 7'h08;
  localparam logic [6:0] IDX_CJ_OFFSET = 7'h09;
  localparam logic [6:0] IDX_STATUS = 7'h0F;
  localparam int WRITE_FLAG_BIT = 7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_SUPPRESS = 8'hFF;
  localparam logic [7:0] RST_CJ_HI = 8'h7F;
  localparam logic [7:0] RST_CJ_LO = 8'hC0;
  localparam logic [7:0] RST_TH_UPPER = 8'h7F;
  localparam logic [7:0] RST_TH_LOWER = 8'hFF;
  localparam logic [7:0] RST_TL_UPPER = 8'h80;
  localparam logic [7:0] RST_TL_LOWER = 8'h00;
  localparam logic [7:0] RST_CJ_OFFSET = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_CJ_RANGE = 7;
  localparam int BIT_TC_RANGE = 6;
  localparam int BIT_CJ_HIGH = 5;
  localparam int BIT_CJ_LOW = 4;
  localparam int BIT_TC_HIGH = 3;
  localparam int BIT_TC_LOW = 2;
  localparam int BIT_VOLT = 1;
  localparam int BIT_OPEN = 0;
  localparam logic [7:0] SUPPRESS_RSVD = 8'hC0;
  localparam logic [7:0] ALARM_SOURCES = 8'h3F;

  // ****************************************
  // Number formats and hysteresis
  // ****************************************
  localparam int TEMP_W = 19;
  localparam int TEMP_FRAC = 7;
  localparam int CJ_W = 14;
  localparam int HYST_DEG = 2;
  localparam logic [TEMP_W:0] HYST_CODE = 20'(HYST_DEG * (2 ** TEMP_FRAC));

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tft_req_type;

  typedef struct packed {
    logic cj_range;
    logic tc_range;
    logic volt_err;
    logic open_tc;
  } tft_flags_type;

  typedef struct packed {
    logic [7:0] suppress;
    logic [7:0] cj_hi;
    logic [7:0] cj_lo;
    logic [7:0] th_upper;
    logic [7:0] th_lower;
    logic [7:0] tl_upper;
    logic [7:0] tl_lower;
    logic [7:0] cj_offset;
  } tft_regs_type;

  typedef struct packed {
    tft_regs_type regs;
    logic [7:0] status;
    logic fault_n;
    logic [CJ_W-1:0] cj_comp;
    logic [7:0] rdata;
    logic rvalid;
  } tft_state_type;

endpackage

// *** core/tft_limit_cmp.sv ***
// Purpose: One limit comparator with optional release hysteresis
// Assumes: Value and limit share the common signed temperature scale
// Notes: Output is registered, one cycle after the inputs

`timescale 1ns/1ns
`default_nettype none

module tft_limit_cmp
  import tft_pkg::*;
#(
  parameter bit HIGH_SIDE = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [TEMP_W-1:0] value,
  input wire logic [TEMP_W-1:0] limit,
  input wire logic hyst_en,
  output logic active
);

  typedef struct packed {
    logic active;
  } tft_cmp_state_type;

  tft_cmp_state_type s_r;
  tft_cmp_state_type s_nxt;

  logic signed [TEMP_W:0] v_ext;
  logic signed [TEMP_W:0] l_ext;
  logic over;
  logic released;

  always_comb begin
    v_ext = $signed({value[TEMP_W-1], value});
    l_ext = $signed({limit[TEMP_W-1], limit});
    if (HIGH_SIDE) begin
      over = v_ext > l_ext;
      released = v_ext <= (l_ext - $signed(HYST_CODE));
    end else begin
      over = v_ext < l_ext;
      released = v_ext >= (l_ext + $signed(HYST_CODE));
    end
    s_nxt = s_r;
    // Stay set until the value backs off by the hysteresis band
    s_nxt.active = over | (hyst_en & s_r.active & ~released);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign active = s_r.active;

endmodule

`default_nettype wire

// *** testbench/tft_host_model.sv ***
// Purpose: Host side of the byte register port
// Assumes: One access per call, request held to its taking edge
// Notes: Released bus carries the inverse of the last values
`timescale 1ns/1ns
`default_nettype none
module tft_host_model
  import tft_pkg::*;
(
  input wire logic clock,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output var tft_req_type req
);
  // ****
  // Access tasks
  // ****
  initial req = '0;
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
    output logic v);
    @(posedge clock);
    req <= '{1'b1, a, d};
    @(posedge clock);
    req <= '{1'b0, ~a, ~d};
    #1;
    q = rdata;
    v = rvalid;
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic v;
    xfer({1'b1, i}, d, q, v);
  endtask
  task automatic rd(input logic [6:0] i, output logic [7:0] q, output logic v);
    xfer({1'b0, i}, 8'h00, q, v);
  endtask
endmodule
`default_nettype wire

// *** testbench/tft_chk.sv ***
// Purpose: Port assertions of the fault threshold block
// Assumes: Bound to tft_fault_limits, one clock domain
// Notes: Suppress byte is shadowed from host writes
`timescale 1ns/1ns
`default_nettype none
module tft_chk
  import tft_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire tft_req_type REG_REQ,
  input wire tft_flags_type FAULT_FLAGS,
  input wire logic INTERRUPT_MODE,
  input wire logic STATUS_CLEAR_STROBE,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic FAULT_N,
  input wire logic [7:0] FAULT_STATUS
);
  // ****
  // Shadow and checks
  // ****
  logic [7:0] sup_r;
  logic rd;
  assign rd = REG_REQ.stb & ~REG_REQ.addr[7];
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST)
      sup_r <= RST_SUPPRESS;
    else if (REG_REQ.stb && REG_REQ.addr == {1'b1, IDX_SUPPRESS})
      sup_r <= REG_REQ.wdata;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence rd_sup_s; rd && REG_REQ.addr[6:0] == IDX_SUPPRESS; endsequence
  sequence held_s; INTERRUPT_MODE && !STATUS_CLEAR_STROBE && FAULT_STATUS[0]; endsequence
  alarm_eq_a:
  assert property ($stable(sup_r) |-> FAULT_N == !(|(FAULT_STATUS[5:0] & ~sup_r[5:0])))
    else $error("alarm level wrong");
  read_pulse_a:
  assert property (REG_RVALID == $past(rd)) else $error("read valid wrong");
  rdata_hold_a:
  assert property (!rd |=> $stable(REG_RDATA)) else $error("read data moved");
  sup_rsvd_a:
  assert property (rd_sup_s |=> REG_RDATA == (sup_r | SUPPRESS_RSVD)) else $error("suppress read");
  flag_follow_a:
  assert property (!INTERRUPT_MODE |=> FAULT_STATUS[6] == $past(FAULT_FLAGS.tc_range)
    && FAULT_STATUS[1] == $past(FAULT_FLAGS.volt_err)) else $error("status not live");
  clr_ignored_a:
  assert property (!INTERRUPT_MODE && FAULT_FLAGS.open_tc |=> FAULT_STATUS[0])
    else $error("open fault lost");
  latch_hold_a:
  assert property (held_s |=> FAULT_STATUS[0]) else $error("latched bit fell");
  clear_open_a:
  assert property (INTERRUPT_MODE && STATUS_CLEAR_STROBE && !FAULT_FLAGS.open_tc
    |=> !FAULT_STATUS[0]) else $error("clear failed");
endmodule
`default_nettype wire

// *** testbench/tft_fault_limits_tb.sv ***
// Purpose: Self-checking bench of the fault threshold block
// Assumes: Host model drives the register port
// Notes: Random bytes come from a fixed-seed xorshift
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tft_fault_limits_tb
  import tft_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tft_req_type req;
  logic [CJ_W-1:0] cj = '0;
  logic en = 1'b0;
  logic [TEMP_W-1:0] tc = '0;
  tft_flags_type fl = '0;
  logic im = 1'b0;
  logic clr = 1'b0;
  logic [7:0] rdat;
  logic [7:0] st;
  logic rv;
  logic fn;
  logic [CJ_W-1:0] cc;
  logic [7:0] q;
  logic v;
  logic [31:0] r;
  logic [31:0] seed = 32'h1129_ddf4;
  int n_mismatch = 0;
  int n_checks = 0;
  int mg [4] = '{2049, 1793, 1792, 2048};
  logic [6:0] ix [10] = '{IDX_SUPPRESS, IDX_CJ_HI, IDX_CJ_LO, IDX_TH_UPPER, IDX_TH_LOWER,
    IDX_TL_UPPER, IDX_TL_LOWER, IDX_CJ_OFFSET, IDX_STATUS, 7'h0A};
  logic [7:0] rs [10] = '{RST_SUPPRESS, RST_CJ_HI, RST_CJ_LO, RST_TH_UPPER, RST_TH_LOWER,
    RST_TL_UPPER, RST_TL_LOWER, RST_CJ_OFFSET, RST_STATUS, 8'h00};
  always #50 clk = ~clk;
  tft_host_model u_host (.clock(clk), .rdata(rdat), .rvalid(rv), .req(req));
  tft_fault_limits u_dut (.CLOCK(clk), .RST(rst), .REG_REQ(req), .CJ_MEASURED(cj),
    .CJ_SENSOR_EN(en), .TC_LINEARIZED(tc), .FAULT_FLAGS(fl), .INTERRUPT_MODE(im),
    .STATUS_CLEAR_STROBE(clr), .REG_RDATA(rdat), .REG_RVALID(rv), .FAULT_N(fn),
    .FAULT_STATUS(st), .CJ_COMPENSATED(cc));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [13:0] cj_exp(logic [13:0] m, logic [7:0] o, logic e);
    int s;
    s = int'($signed(m));
    if (e)
      s += 4 * int'($signed(o));
    if (s > 8191)
      s = 8191;
    if (s < -8192)
      s = -8192;
    return 14'(s);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    u_host.wr(IDX_STATUS, 8'hFF);
    u_host.wr(7'h0A, 8'h55);
    for (int i = 0; i < 10; i++) begin
      u_host.rd(ix[i], q, v);
      `CHK("rvalid", 1'b1, v)
      `CHK("reset", rs[i], q)
    end
    // Flags under random suppress, corners first
    for (int k = 0; k < 8; k++) begin
      r = (k == 0) ? 32'h0000_000F : (k == 1) ? 32'h0000_000C : rnd();
      @(posedge clk);
      fl <= r[3:0];
      u_host.wr(IDX_SUPPRESS, r[15:8]);
      tick(2);
      `CHK("status", {r[3:2], 4'h0, r[1:0]}, st)
      `CHK("alarm", !(|(r[1:0] & ~r[9:8])), fn)
    end
    @(posedge clk);
    fl <= '0;
    u_host.wr(IDX_SUPPRESS, 8'h00);
    u_host.wr(IDX_TH_UPPER, 8'h01);
    u_host.wr(IDX_TH_LOWER, 8'h00);
    u_host.wr(IDX_TL_UPPER, 8'hFF);
    // Limits +-16.0 C: set, hold in hysteresis, release, equal
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      tc <= (i < 4) ? TEMP_W'(mg[i]) : TEMP_W'(-mg[i - 4]);
      tick(4);
      `CHK("tc high", i < 2, st[BIT_TC_HIGH])
      `CHK("tc low", i == 4 || i == 5, st[BIT_TC_LOW])
    end
    @(posedge clk);
    tc <= '0;
    cj <= 14'h0120;
    en <= 1'b1;
    u_host.wr(IDX_CJ_OFFSET, 8'h10);
    u_host.wr(IDX_CJ_HI, 8'h05);
    u_host.wr(IDX_CJ_LO, 8'hFC);
    tick(4);
    `CHK("cj comp", cj_exp(14'h0120, 8'h10, 1'b1), cc)
    `CHK("cj flags", 2'h2, st[5:4])
    @(posedge clk);
    cj <= 14'h3EE0;
    en <= 1'b0;
    tick(4);
    `CHK("cj comp", cj_exp(14'h3EE0, 8'h10, 1'b0), cc)
    `CHK("cj flags", 2'h1, st[5:4])
    @(posedge clk);
    cj <= 14'h1FF0;
    en <= 1'b1;
    tick(4);
    `CHK("cj sat", cj_exp(14'h1FF0, 8'h10, 1'b1), cc)
    `CHK("cj flags", 2'h2, st[5:4])
    @(posedge clk);
    cj <= '0;
    u_host.wr(IDX_SUPPRESS, 8'hFE);
    tick(4);
    im <= 1'b1;
    fl <= 4'h1;
    @(posedge clk);
    fl <= 4'h0;
    tick(4);
    `CHK("latched", 8'h01, st)
    `CHK("alarm", 1'b0, fn)
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tick(1);
    `CHK("cleared", 8'h00, st)
    `CHK("alarm", 1'b1, fn)
    fl <= 4'h1;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    fl <= 4'h0;
    tick(2);
    `CHK("set wins", 8'h01, st)
    im <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      u_host.wr(ix[i], r[7:0]);
      u_host.rd(ix[i], q, v);
      `CHK("readback", (i == 0) ? (r[7:0] | SUPPRESS_RSVD) : r[7:0], q)
    end
    tally_and_finish();
  end
  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
bind tft_fault_limits tft_chk u_chk (.CLOCK(CLOCK), .RST(RST), .REG_REQ(REG_REQ),
  .FAULT_FLAGS(FAULT_FLAGS), .INTERRUPT_MODE(INTERRUPT_MODE), .REG_RDATA(REG_RDATA),
  .STATUS_CLEAR_STROBE(STATUS_CLEAR_STROBE), .REG_RVALID(REG_RVALID), .FAULT_N(FAULT_N),
  .FAULT_STATUS(FAULT_STATUS));
`default_nettype wire
